// [eagc_cfg.svh]
// Offsets, field positions and reset values of the expander address and event control block.
`ifndef EAGC_CFG_SVH
`define EAGC_CFG_SVH

`define EAGC_ADDR_W 12
`define EAGC_DATA_W 32

`define EAGC_OFF_EXP_LOW 12'h434
`define EAGC_OFF_EXP_HIGH 12'h438
`define EAGC_OFF_EVT_CTL 12'h450
`define EAGC_OFF_IRQ_STATUS 12'h4E0
`define EAGC_OFF_IRQ_MASK 12'h4E4

`define EAGC_NUM_EXP 5
`define EAGC_EXP_LOW_COUNT 4
`define EAGC_EXP_ADDR_W 7
`define EAGC_EXP_ID_W 3
`define EAGC_EXP_FIELD_LSB 1
`define EAGC_EXP_FIELD_STRIDE 8
`define EAGC_EXP_ADDR_RST 7'h00

`define EAGC_NUM_PORTS 6
`define EAGC_POL_BIT 0
`define EAGC_REDIR_LSB 1
`define EAGC_POL_RST 1'b0
`define EAGC_REDIR_RST 6'h00
`define EAGC_PIN_RST 1'b1

`define EAGC_IRQ_W 6
`define EAGC_IRQ_LOCK_BIT 5
`define EAGC_IRQ_RST 6'h00

`define EAGC_RDATA_RST 32'h0000_0000

`endif

// [eagc_pkg.sv]
// Types shared by the expander address and event control block.
package eagc_pkg;

    typedef struct packed {
        logic [2:0] id;
        logic [6:0] addr;
    } eagc_exp_req_t;

    typedef struct packed {
        logic invert;
        logic [5:0] redirect;
    } eagc_evt_ctl_t;

    typedef enum logic [1:0] {
        EAGC_INIT_IDLE,
        EAGC_INIT_ISSUE,
        EAGC_INIT_WAIT
    } eagc_init_state_t;

endpackage

// [eagc_event_route.sv]
// Per-port event redirection and event output pin level generation.
`timescale 1ns/1ps
`include "eagc_cfg.svh"

module eagc_event_route #(
    parameter int NUM_PORTS = `EAGC_NUM_PORTS
) (
    input wire logic clk, // System clock.
    input wire logic reset_n, // Fundamental reset, asynchronous.
    input wire logic hot_clear, // Lesser reset, synchronous.
    input wire eagc_pkg::eagc_evt_ctl_t ctl, // Polarity and redirect enables.
    input wire logic [NUM_PORTS-1:0] port_event, // Event requests from ports 1 up.
    output logic [NUM_PORTS-1:0] notify_allow, // Standard notifications allowed.
    output logic [NUM_PORTS-1:0] event_status, // Port signalling an event.
    output logic pin_level // Event output level at the pin.
);

    logic [NUM_PORTS-1:0] status_next;
    logic [NUM_PORTS-1:0] status_reg;
    logic pin_reg;
    logic pin_next;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++)
        begin : g_port
            // A redirected port loses its own notifications and raises the shared event.
            assign notify_allow[gi] = ~ctl.redirect[gi];
            // Status can only rise for a port whose redirect is enabled.
            assign status_next[gi] = ctl.redirect[gi] & port_event[gi];
        end
    endgenerate

    // Active low unless inverted.
    assign pin_next = ctl.invert ? (|status_next) : ~(|status_next);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_reg <= '0;
            pin_reg <= `EAGC_PIN_RST;
        end
        else if (hot_clear)
        begin
            status_reg <= '0;
            pin_reg <= ~ctl.invert;
        end
        else
        begin
            status_reg <= status_next;
            pin_reg <= pin_next;
        end
    end

    assign event_status = status_reg;
    assign pin_level = pin_reg;

endmodule

// [eagc_expander_init.sv]
// Sequencer that starts one expander initialization at a time.
`timescale 1ns/1ps
`include "eagc_cfg.svh"

module eagc_expander_init #(
    parameter int NUM_EXP = `EAGC_NUM_EXP
) (
    input wire logic clk, // System clock.
    input wire logic reset_n, // Fundamental reset, asynchronous.
    input wire logic hot_clear, // Lesser reset, synchronous.
    input wire logic [NUM_EXP-1:0] start, // Address field written, one per expander.
    input wire logic [NUM_EXP*`EAGC_EXP_ADDR_W-1:0] addr_flat, // Current addresses.
    input wire logic [`EAGC_EXP_ID_W-1:0] selected, // Expander chosen by select.
    input wire logic init_done, // Engine finished the request.
    output logic init_req, // Request pulse to the engine.
    output eagc_pkg::eagc_exp_req_t req, // Expander number and address.
    output logic done_set, // Pulse that sets the done flag.
    output logic [NUM_EXP-1:0] finished // Pulse per expander on completion.
);

    eagc_pkg::eagc_init_state_t state_reg;
    eagc_pkg::eagc_init_state_t state_next;
    logic [NUM_EXP-1:0] pending_reg;
    logic [NUM_EXP-1:0] pending_next;
    logic [NUM_EXP-1:0] pick_onehot;
    logic [`EAGC_EXP_ID_W-1:0] pick_id;
    eagc_pkg::eagc_exp_req_t req_reg;
    eagc_pkg::eagc_exp_req_t req_next;
    logic issue;
    logic complete;

    function automatic logic [`EAGC_EXP_ID_W-1:0] lowest_id(input logic [NUM_EXP-1:0] v);
        logic [`EAGC_EXP_ID_W-1:0] r;
        r = '0;
        for (int k = NUM_EXP - 1; k >= 0; k--)
        begin
            if (v[k])
            begin
                r = `EAGC_EXP_ID_W'(k);
            end
        end
        return r;
    endfunction

    assign pick_id = lowest_id(pending_reg);
    assign pick_onehot = NUM_EXP'(1) << pick_id;
    assign issue = (state_reg == eagc_pkg::EAGC_INIT_ISSUE);
    assign complete = (state_reg == eagc_pkg::EAGC_INIT_WAIT) && init_done;
    // A new write in the issue cycle keeps the expander pending, so it is run again.
    assign pending_next = (pending_reg & ~(issue ? pick_onehot : '0)) | start;
    assign req_next.id = issue ? pick_id : req_reg.id;
    assign req_next.addr = issue ? addr_flat[pick_id*`EAGC_EXP_ADDR_W +: `EAGC_EXP_ADDR_W]
                                 : req_reg.addr;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            eagc_pkg::EAGC_INIT_IDLE:
            begin
                if (|pending_reg)
                begin
                    state_next = eagc_pkg::EAGC_INIT_ISSUE;
                end
            end
            eagc_pkg::EAGC_INIT_ISSUE:
            begin
                state_next = eagc_pkg::EAGC_INIT_WAIT;
            end
            eagc_pkg::EAGC_INIT_WAIT:
            begin
                if (init_done)
                begin
                    state_next = eagc_pkg::EAGC_INIT_IDLE;
                end
            end
            default:
            begin
                state_next = eagc_pkg::EAGC_INIT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= eagc_pkg::EAGC_INIT_IDLE;
            pending_reg <= '0;
            req_reg <= '0;
        end
        else if (hot_clear)
        begin
            state_reg <= eagc_pkg::EAGC_INIT_IDLE;
            pending_reg <= '0;
            req_reg <= req_reg;
        end
        else
        begin
            state_reg <= state_next;
            pending_reg <= pending_next;
            req_reg <= req_next;
        end
    end

    assign init_req = (state_reg == eagc_pkg::EAGC_INIT_WAIT) && (state_next != state_reg)
                      ? 1'b0 : (state_reg == eagc_pkg::EAGC_INIT_ISSUE);
    assign req = req_next;
    // Done is flagged only for the expander currently selected.
    assign done_set = complete && (req_reg.id == selected);
    assign finished = complete ? (NUM_EXP'(1) << req_reg.id) : '0;

endmodule

// [eagc_regs.sv]
// Expander address and port event control register bank.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "eagc_cfg.svh"


module eagc_regs #(
    parameter int NUM_EXP = `EAGC_NUM_EXP,
    parameter int NUM_PORTS = `EAGC_NUM_PORTS
) (
    input wire logic CLK_SYS, // System clock, 100 MHz.
    input wire logic RESET_N, // Fundamental reset, asynchronous, active low.
    input wire logic HOT_RESET, // Lesser reset, synchronous, active high.
    input wire logic [`EAGC_ADDR_W-1:0] REG_ADDR, // Register byte address.
    input wire logic [`EAGC_DATA_W-1:0] REG_WDATA, // Register write data.
    input wire logic REG_WR, // Write strobe.
    input wire logic REG_RD, // Read strobe.
    output logic [`EAGC_DATA_W-1:0] REG_RDATA, // Read data, one cycle after the strobe.
    input wire logic REG_LOCK, // Register lock condition.
    input wire logic [NUM_PORTS-1:0] PORT_EVENT, // Hot-plug and PME events, ports 1 up.
    output logic [NUM_PORTS-1:0] PORT_NOTIFY_EN, // Standard notifications allowed.
    output logic [NUM_PORTS-1:0] PORT_EVENT_STATUS, // Port is signalling an event.
    input wire logic GPIO7_ALT_EN, // Pin 7 set to its alternate function.
    input wire logic GPIO7_GP_DATA, // Pin 7 data from the general purpose logic.
    input wire logic GPIO7_GP_OE, // Pin 7 enable from the general purpose logic.
    output logic GPIO7_OUT, // Pin 7 output level.
    output logic GPIO7_OE, // Pin 7 output enable.
    output logic EXP_INIT_REQ, // Start an expander initialization.
    output logic [`EAGC_EXP_ID_W-1:0] EXP_INIT_ID, // Expander to initialize.
    output logic [`EAGC_EXP_ADDR_W-1:0] EXP_INIT_ADDR, // Bus address to use.
    input wire logic EXP_INIT_DONE, // Initialization finished.
    input wire logic [`EAGC_EXP_ID_W-1:0] EXP_SELECT, // Expander select field.
    output logic EXP_DONE_SET, // Set the expander done flag.
    output logic IRQ // Level interrupt.
);

    logic [`EAGC_EXP_ADDR_W-1:0] exp_addr_reg [NUM_EXP];
    logic [`EAGC_EXP_ADDR_W-1:0] exp_addr_next [NUM_EXP];
    logic [NUM_EXP*`EAGC_EXP_ADDR_W-1:0] exp_addr_flat;
    logic [NUM_EXP-1:0] exp_start;
    eagc_pkg::eagc_evt_ctl_t evt_ctl_reg;
    eagc_pkg::eagc_evt_ctl_t evt_ctl_next;
    logic [`EAGC_IRQ_W-1:0] irq_status_reg;
    logic [`EAGC_IRQ_W-1:0] irq_status_next;
    logic [`EAGC_IRQ_W-1:0] irq_mask_reg;
    logic [`EAGC_IRQ_W-1:0] irq_mask_next;
    logic [`EAGC_IRQ_W-1:0] irq_events;
    logic [`EAGC_DATA_W-1:0] rdata_reg;
    logic [`EAGC_DATA_W-1:0] rdata_next;
    logic [`EAGC_DATA_W-1:0] exp_low_word;
    logic [`EAGC_DATA_W-1:0] exp_high_word;
    logic [`EAGC_DATA_W-1:0] evt_ctl_word;
    logic [NUM_EXP-1:0] exp_finished;
    logic pin_level;
    logic gpio_out_reg;
    logic gpio_out_next;
    logic sel_exp_low;
    logic sel_exp_high;
    logic sel_evt_ctl;
    logic sel_irq_status;
    logic sel_irq_mask;
    logic wr_exp_low;
    logic wr_exp_high;
    logic wr_evt_ctl;
    logic wr_irq_mask;
    logic rd_irq_status;
    logic locked_write;
    eagc_pkg::eagc_exp_req_t init_req_bus;

    function automatic logic hit(input logic [`EAGC_ADDR_W-1:0] a,
                                 input logic [`EAGC_ADDR_W-1:0] off);
        return a == off;
    endfunction

    function automatic logic [`EAGC_EXP_ADDR_W-1:0] field_of(input logic [`EAGC_DATA_W-1:0] w,
                                                             input int slot);
        return w[`EAGC_EXP_FIELD_LSB + slot*`EAGC_EXP_FIELD_STRIDE +: `EAGC_EXP_ADDR_W];
    endfunction

    // Address decode.
    assign sel_exp_low = hit(REG_ADDR, `EAGC_OFF_EXP_LOW);
    assign sel_exp_high = hit(REG_ADDR, `EAGC_OFF_EXP_HIGH);
    assign sel_evt_ctl = hit(REG_ADDR, `EAGC_OFF_EVT_CTL);
    assign sel_irq_status = hit(REG_ADDR, `EAGC_OFF_IRQ_STATUS);
    assign sel_irq_mask = hit(REG_ADDR, `EAGC_OFF_IRQ_MASK);

    // Locked writes to the address registers are dropped and only reported.
    assign wr_exp_low = REG_WR && sel_exp_low && !REG_LOCK;
    assign wr_exp_high = REG_WR && sel_exp_high && !REG_LOCK;
    assign locked_write = REG_WR && (sel_exp_low || sel_exp_high) && REG_LOCK;
    assign wr_evt_ctl = REG_WR && sel_evt_ctl;
    assign wr_irq_mask = REG_WR && sel_irq_mask;
    assign rd_irq_status = REG_RD && sel_irq_status;

    // Expander address fields, four in the low word and one in the high word.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXP; gi++)
        begin : g_exp
            if (gi < `EAGC_EXP_LOW_COUNT)
            begin : g_low
                assign exp_start[gi] = wr_exp_low;
                assign exp_addr_next[gi] = wr_exp_low ? field_of(REG_WDATA, gi)
                                                      : exp_addr_reg[gi];
            end
            else
            begin : g_high
                assign exp_start[gi] = wr_exp_high;
                assign exp_addr_next[gi] = wr_exp_high
                    ? field_of(REG_WDATA, gi - `EAGC_EXP_LOW_COUNT)
                    : exp_addr_reg[gi];
            end
            assign exp_addr_flat[gi*`EAGC_EXP_ADDR_W +: `EAGC_EXP_ADDR_W] = exp_addr_reg[gi];

            // Sticky: only the fundamental reset clears the address.
            always_ff @(posedge CLK_SYS or negedge RESET_N)
            begin
                if (!RESET_N)
                begin
                    exp_addr_reg[gi] <= `EAGC_EXP_ADDR_RST;
                end
                else
                begin
                    exp_addr_reg[gi] <= exp_addr_next[gi];
                end
            end
        end
    endgenerate

    // Read views with the reserved bits at zero.
    always_comb
    begin
        exp_low_word = '0;
        exp_high_word = '0;
        for (int k = 0; k < NUM_EXP; k++)
        begin
            if (k < `EAGC_EXP_LOW_COUNT)
            begin
                exp_low_word[`EAGC_EXP_FIELD_LSB + k*`EAGC_EXP_FIELD_STRIDE +: `EAGC_EXP_ADDR_W]
                    = exp_addr_reg[k];
            end
            else
            begin
                exp_high_word[`EAGC_EXP_FIELD_LSB
                              + (k - `EAGC_EXP_LOW_COUNT)*`EAGC_EXP_FIELD_STRIDE
                              +: `EAGC_EXP_ADDR_W] = exp_addr_reg[k];
            end
        end
    end

    // Event control: polarity in bit 0, redirects for ports 1 to 6 above it.
    assign evt_ctl_next.invert = wr_evt_ctl ? REG_WDATA[`EAGC_POL_BIT] : evt_ctl_reg.invert;
    assign evt_ctl_next.redirect = wr_evt_ctl ? REG_WDATA[`EAGC_REDIR_LSB +: NUM_PORTS]
                                              : evt_ctl_reg.redirect;
    assign evt_ctl_word = {{(`EAGC_DATA_W - NUM_PORTS - 1){1'b0}},
                           evt_ctl_reg.redirect, evt_ctl_reg.invert};

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            evt_ctl_reg.invert <= `EAGC_POL_RST;
            evt_ctl_reg.redirect <= `EAGC_REDIR_RST;
        end
        else
        begin
            evt_ctl_reg <= evt_ctl_next;
        end
    end

    eagc_event_route #(
        .NUM_PORTS(NUM_PORTS)
    ) u_route (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .hot_clear(HOT_RESET),
        .ctl(evt_ctl_reg),
        .port_event(PORT_EVENT),
        .notify_allow(PORT_NOTIFY_EN),
        .event_status(PORT_EVENT_STATUS),
        .pin_level(pin_level)
    );

    eagc_expander_init #(
        .NUM_EXP(NUM_EXP)
    ) u_init (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .hot_clear(HOT_RESET),
        .start(exp_start),
        .addr_flat(exp_addr_flat),
        .selected(EXP_SELECT),
        .init_done(EXP_INIT_DONE),
        .init_req(EXP_INIT_REQ),
        .req(init_req_bus),
        .done_set(EXP_DONE_SET),
        .finished(exp_finished)
    );

    assign EXP_INIT_ID = init_req_bus.id;
    assign EXP_INIT_ADDR = init_req_bus.addr;

    // Pin 7 carries the event output when its alternate function is chosen.
    assign gpio_out_next = GPIO7_ALT_EN ? pin_level : GPIO7_GP_DATA;
    assign GPIO7_OE = GPIO7_ALT_EN | GPIO7_GP_OE;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            gpio_out_reg <= `EAGC_PIN_RST;
        end
        else
        begin
            gpio_out_reg <= gpio_out_next;
        end
    end

    assign GPIO7_OUT = gpio_out_reg;

    // Interrupt status: expander completions and rejected locked writes.
    // A new event in the cycle of the clearing read is kept.
    assign irq_events = {locked_write, exp_finished};
    assign irq_status_next = (rd_irq_status ? '0 : irq_status_reg) | irq_events;
    assign irq_mask_next = wr_irq_mask ? REG_WDATA[`EAGC_IRQ_W-1:0] : irq_mask_reg;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            irq_status_reg <= `EAGC_IRQ_RST;
            irq_mask_reg <= `EAGC_IRQ_RST;
        end
        else if (HOT_RESET)
        begin
            irq_status_reg <= `EAGC_IRQ_RST;
            irq_mask_reg <= `EAGC_IRQ_RST;
        end
        else
        begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    assign IRQ = |(irq_status_reg & irq_mask_reg);

    // Read data mux; unmapped addresses read zero.
    assign rdata_next = !REG_RD ? `EAGC_RDATA_RST
        : sel_exp_low ? exp_low_word
        : sel_exp_high ? exp_high_word
        : sel_evt_ctl ? evt_ctl_word
        : sel_irq_status ? {{(`EAGC_DATA_W - `EAGC_IRQ_W){1'b0}}, irq_status_reg}
        : sel_irq_mask ? {{(`EAGC_DATA_W - `EAGC_IRQ_W){1'b0}}, irq_mask_reg}
        : `EAGC_RDATA_RST;

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rdata_reg <= `EAGC_RDATA_RST;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA = rdata_reg;

endmodule

// [eagc_regs_asserts.sv]
// Concurrent checks on the ports of the expander address and event control bank.
`timescale 1ns/1ps
`include "eagc_cfg.svh"

module eagc_regs_asserts #(
    parameter int NUM_PORTS = 6
) (
    input wire logic CLK_SYS, // Clock.
    input wire logic RESET_N, // Reset.
    input wire logic HOT_RESET, // Lesser reset.
    input wire logic [`EAGC_ADDR_W-1:0] REG_ADDR, // Address.
    input wire logic REG_WR, // Write strobe.
    input wire logic REG_RD, // Read strobe.
    input wire logic [`EAGC_DATA_W-1:0] REG_RDATA, // Read data.
    input wire logic [NUM_PORTS-1:0] PORT_EVENT, // Port events.
    input wire logic [NUM_PORTS-1:0] PORT_NOTIFY_EN, // Notify enables.
    input wire logic [NUM_PORTS-1:0] PORT_EVENT_STATUS, // Event status.
    input wire logic GPIO7_ALT_EN, // Alternate function.
    input wire logic GPIO7_GP_DATA, // Plain pin data.
    input wire logic GPIO7_GP_OE, // Plain pin enable.
    input wire logic GPIO7_OUT, // Pin level.
    input wire logic GPIO7_OE, // Pin enable.
    input wire logic [`EAGC_EXP_ID_W-1:0] EXP_INIT_ID, // Expander served.
    input wire logic EXP_INIT_DONE, // Engine done.
    input wire logic [`EAGC_EXP_ID_W-1:0] EXP_SELECT, // Selected expander.
    input wire logic EXP_DONE_SET // Done flag set.
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    property p_status_cause;
        $past(RESET_N) && !$past(HOT_RESET) |->
            PORT_EVENT_STATUS == ($past(PORT_EVENT) & ~$past(PORT_NOTIFY_EN));
    endproperty
    a_status_cause: assert property (p_status_cause)
        else $error("event status does not follow redirected events");
    property p_pin_toggle;
        $past(RESET_N, 2) && $past(GPIO7_ALT_EN) && $past(GPIO7_ALT_EN, 2) && !$past(REG_WR, 3)
            && (|$past(PORT_EVENT_STATUS) != |$past(PORT_EVENT_STATUS, 2))
            |-> GPIO7_OUT != $past(GPIO7_OUT);
    endproperty
    a_pin_toggle: assert property (p_pin_toggle)
        else $error("event pin did not change with the event status");
    property p_gp_path;
        $past(RESET_N) && !$past(GPIO7_ALT_EN) |-> GPIO7_OUT == $past(GPIO7_GP_DATA);
    endproperty
    a_gp_path: assert property (p_gp_path)
        else $error("pin 7 does not carry plain data");
    property p_oe;
        GPIO7_OE == (GPIO7_ALT_EN | GPIO7_GP_OE);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin 7 enable wrong");
    property p_rsvd_low;
        $past(REG_RD) && $past(REG_ADDR) == `EAGC_OFF_EXP_LOW
            |-> {REG_RDATA[24], REG_RDATA[16], REG_RDATA[8], REG_RDATA[0]} == 4'h0;
    endproperty
    a_rsvd_low: assert property (p_rsvd_low)
        else $error("reserved bit of low address register set");
    property p_rsvd_high;
        $past(REG_RD) && $past(REG_ADDR) == `EAGC_OFF_EXP_HIGH
            |-> REG_RDATA[31:8] == 24'h000000 && !REG_RDATA[0];
    endproperty
    a_rsvd_high: assert property (p_rsvd_high)
        else $error("reserved bit of high address register set");
    property p_rsvd_ctl;
        $past(REG_RD) && $past(REG_ADDR) == `EAGC_OFF_EVT_CTL |-> REG_RDATA[31:7] == 25'h0000000;
    endproperty
    a_rsvd_ctl: assert property (p_rsvd_ctl)
        else $error("reserved bit of event control set");
    property p_done_set;
        EXP_DONE_SET |-> EXP_INIT_DONE && EXP_SELECT == EXP_INIT_ID;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done flag set for an unselected expander");
    property p_hot_keep;
        $past(RESET_N) && $past(HOT_RESET) && !$past(REG_WR) |-> $stable(PORT_NOTIFY_EN);
    endproperty
    a_hot_keep: assert property (p_hot_keep)
        else $error("lesser reset changed the redirect bits");

    c_redirect: cover property (|PORT_EVENT_STATUS);
    c_done: cover property (EXP_DONE_SET);
    c_hot: cover property (HOT_RESET);
endmodule

bind eagc_regs eagc_regs_asserts #(.NUM_PORTS(NUM_PORTS)) u_eagc_regs_asserts (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .HOT_RESET(HOT_RESET), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PORT_EVENT(PORT_EVENT),
    .PORT_NOTIFY_EN(PORT_NOTIFY_EN), .PORT_EVENT_STATUS(PORT_EVENT_STATUS),
    .GPIO7_ALT_EN(GPIO7_ALT_EN), .GPIO7_GP_DATA(GPIO7_GP_DATA), .GPIO7_GP_OE(GPIO7_GP_OE),
    .GPIO7_OUT(GPIO7_OUT), .GPIO7_OE(GPIO7_OE), .EXP_INIT_ID(EXP_INIT_ID),
    .EXP_INIT_DONE(EXP_INIT_DONE), .EXP_SELECT(EXP_SELECT), .EXP_DONE_SET(EXP_DONE_SET));

// [eagc_regs_bench.sv]
// Self-checking testbench of the expander address and event control bank.
`timescale 1ns/1ps

module eagc_regs_bench;
    logic clk_sys, reset_n, hot_reset, reg_wr, reg_rd, reg_lock, exp_init_done;
    logic alt_en, gp_data, gp_oe, gpio7_out, gpio7_oe, exp_init_req, exp_done_set, irq;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0] port_event, notify_en, event_status;
    logic [2:0] exp_init_id, exp_select;
    logic [6:0] exp_init_addr;
    logic [9:0] seen[$];
    logic [31:0] ctl_tab[3] = '{32'h0000_0000, 32'h0000_000A, 32'h0000_000B};
    int n_errors, comparisons, n_done;

    eagc_regs u_eagc_regs (.CLK_SYS(clk_sys), .RESET_N(reset_n), .HOT_RESET(hot_reset),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .REG_LOCK(reg_lock), .PORT_EVENT(port_event),
        .PORT_NOTIFY_EN(notify_en), .PORT_EVENT_STATUS(event_status), .GPIO7_ALT_EN(alt_en),
        .GPIO7_GP_DATA(gp_data), .GPIO7_GP_OE(gp_oe), .GPIO7_OUT(gpio7_out), .GPIO7_OE(gpio7_oe),
        .EXP_INIT_REQ(exp_init_req), .EXP_INIT_ID(exp_init_id), .EXP_INIT_ADDR(exp_init_addr),
        .EXP_INIT_DONE(exp_init_done), .EXP_SELECT(exp_select), .EXP_DONE_SET(exp_done_set),
        .IRQ(irq));

    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Stand-in for the expander engine: answers each request three cycles later.
    always @(negedge clk_sys)
        if (exp_init_req === 1'b1)
        begin
            seen.push_back({exp_init_id, exp_init_addr});
            repeat (3) @(posedge clk_sys);
            exp_init_done <= 1'b1;
            @(posedge clk_sys);
            exp_init_done <= 1'b0;
        end

    always @(negedge clk_sys)
        if (exp_done_set === 1'b1)
            n_done++;

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        {reset_n, hot_reset, reg_wr, reg_rd, reg_lock, exp_init_done} = 6'h00;
        {alt_en, gp_data, gp_oe, reg_addr, reg_wdata, port_event} = 53'h0;
        exp_select = 3'h2;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(12'h434, 32'h0, "low reset");
        rd(12'h438, 32'h0, "high reset");
        rd(12'h450, 32'h0, "ctl reset");
        wr(12'h4E4, 32'h0000_001F);
        wr(12'h434, 32'h8866_4422);
        wr(12'h438, 32'hFFFF_FF9A);
        wr(12'h450, 32'hFFFF_FFFF);
        repeat (60) @(posedge clk_sys);
        check("init count", 32'(seen.size()), 32'h5);
        for (int i = 0; i < 5; i++)
            check("init req", 32'(seen[i]), 32'({3'(i), 7'(i < 4 ? (i + 1) * 17 : 77)}));
        check("done flag", 32'(n_done), 32'h1);
        rd(12'h434, 32'h8866_4422, "low fields");
        rd(12'h438, 32'h0000_009A, "high field");
        rd(12'h450, 32'h0000_007F, "ctl fields");
        check("irq set", 32'(irq), 32'h1);
        rd(12'h4E0, 32'h0000_001F, "irq status");
        check("irq cleared", 32'(irq), 32'h0);
        @(posedge clk_sys);
        reg_lock <= 1'b1;
        wr(12'h434, 32'h0);
        reg_lock <= 1'b0;
        repeat (5) @(posedge clk_sys);
        check("locked init", 32'(seen.size()), 32'h5);
        check("irq masked", 32'(irq), 32'h0);
        rd(12'h434, 32'h8866_4422, "locked write");
        rd(12'h4E0, 32'h0000_0020, "lock status");
        wr(12'h440, 32'hFFFF_FFFF);
        rd(12'h440, 32'h0, "unmapped");
        @(posedge clk_sys);
        alt_en <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            wr(12'h450, ctl_tab[k]);
            port_event <= 6'h3F;
            repeat (3) @(posedge clk_sys);
            #1;
            check("notify", 32'(notify_en), {26'h0, ~ctl_tab[k][6:1]});
            check("status", 32'(event_status), 32'(ctl_tab[k][6:1]));
            check("pin on", 32'(gpio7_out), 32'(ctl_tab[k][0] ^ ~|ctl_tab[k][6:1]));
            @(posedge clk_sys);
            port_event <= 6'h00;
            repeat (3) @(posedge clk_sys);
            #1;
            check("pin off", 32'(gpio7_out), {31'h0, ~ctl_tab[k][0]});
        end
        @(posedge clk_sys);
        hot_reset <= 1'b1;
        @(posedge clk_sys);
        hot_reset <= 1'b0;
        rd(12'h450, 32'h0000_000B, "ctl hot");
        rd(12'h434, 32'h8866_4422, "low hot");
        @(posedge clk_sys);
        alt_en <= 1'b0;
        gp_data <= 1'b1;
        gp_oe <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check("gp out", 32'({gpio7_out, gpio7_oe}), 32'h3);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(12'h434, 32'h0, "low cold");
        rd(12'h450, 32'h0, "ctl cold");
        give_verdict();
    end
endmodule
